// ===== pdb_bert_top.sv
// packet-mode bit error rate test engine with Wishbone register slave
// assumes line clock and receive bits arrive asynchronously on pins
// Operation
// R1: idle-fill interval set 0 to 150 ms in 10 ms steps.
// R2: data burst length set 100 to 1000 ms in 100 ms steps.
// R3: packet traffic cuts the running 511/2047 pattern into bursts.
// R4: packet mode only allowed at 56 or 64 kbit/s.
// R5: packet setup opens on restart after pattern sync is held; code opens it only when all error counts are also zero.
// R6: in setup one command toggles packet mode, another leaves setup.
// R7: packet mode stays on until stop or switched off in setup.
// R8: packet errors reported as bit errors, errored seconds and ratio.
// R9: encoder sends user byte S ddd ddd C; C zero means control code.
// R10: received byte shown byte aligned and stable, fixed rotation allowed.
// R11: received byte classed known data, known code, unknown data, unknown code.
// R12: latch select code takes its value from the encoder byte switches.
// R13: each primary insert flips exactly six transmitted pattern bits.
// R14: each secondary insert flips one bit, only with secondary active.
// R15: in loopback each inserted error raises the bit error count.
// R16: restart zeroes all error counts and restarts elapsed time.
// R17: restart clears primary and secondary counts together.
// R18: restart with all counts zero steps the error analysis view.
// R19: secondary checker shows sync loss until locked, then counts.
// R20: 2047 generator is maximal length 2^11 minus 1.
// R21: packet bursts separated by control idle fill, not pattern bits.
// R22: errored seconds count seconds holding at least one bit error.
// R23: checker pauses in idle fill and resumes on the continuing pattern.
// R24: errored seconds aligned to elapsed-time second tick, restarted by restart.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
module pdb_bert_top #(
    parameter int MS_CYCLES = pdb_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_clk_i,
    input wire logic rx_pri_i,
    input wire logic rx_sec_i,
    output logic tx_pri_o,
    output logic tx_sec_o,
    output logic sync_pri_o,
    output logic sync_sec_o,
    output logic pkt_on_o
);
    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);
    localparam logic [9:0] SEC_LAST = 10'(pdb_pkg::MS_PER_SEC - 1);

    // pin synchronisers: bit0 line clock, bit1 primary rx, bit2 secondary rx
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] pin_q;
    logic line_prev_q;
    logic stb;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            pin_q <= 3'h0;
            line_prev_q <= 1'b0;
        end else begin
            s1_q <= {rx_sec_i, rx_pri_i, line_clk_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= ((s2_q ^ s3_q) & pin_q) | (~(s2_q ^ s3_q) & s3_q);
            line_prev_q <= pin_q[0];
        end
    end

    assign stb = pin_q[0] & ~line_prev_q;

    // wishbone slave: ack one cycle after request, writes act at the ack edge
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic wr;
    logic [5:0] cmd;

    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ack_q & wb_sel_i[0];
    assign cmd = (wr && wb_adr_i == pdb_pkg::ADR_CMD) ? wb_dat_i[5:0] : 6'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // control, packet timing and encoder byte registers
    logic [6:0] ctrl_q;
    logic [7:0] pkt_q;
    logic [7:0] byte_q;
    logic rate_ok;
    logic byte_mode;
    logic run;
    logic sec_on;

    assign rate_ok = ctrl_q[pdb_pkg::CTRL_RATE +: 2] == pdb_pkg::RATE_56K
        || ctrl_q[pdb_pkg::CTRL_RATE +: 2] == pdb_pkg::RATE_64K;
    assign byte_mode = ctrl_q[pdb_pkg::CTRL_ENC] | ctrl_q[pdb_pkg::CTRL_LSC];
    assign run = ctrl_q[pdb_pkg::CTRL_RUN];
    assign sec_on = run & ctrl_q[pdb_pkg::CTRL_SEC_EN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= pdb_pkg::CTRL_RESET;
        end else if (cmd[pdb_pkg::CMD_STOP]) begin
            ctrl_q[pdb_pkg::CTRL_RUN] <= 1'b0;
        end else if (wr && wb_adr_i == pdb_pkg::ADR_CTRL) begin
            ctrl_q <= wb_dat_i[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pkt_q <= pdb_pkg::PKT_RESET;
            byte_q <= pdb_pkg::BYTE_RESET;
        end else begin
            if (wr && wb_adr_i == pdb_pkg::ADR_PKT) begin
                pkt_q <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == pdb_pkg::ADR_BYTE) begin
                byte_q <= wb_dat_i[7:0];
            end
        end
    end

    // interval lengths in ms, steps clamped to the legal range
    logic [9:0] idle_ms;
    logic [9:0] data_ms;

    function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    assign idle_ms = 10'(clamp(pkt_q[pdb_pkg::PKT_IDLE_LSB +: 4], 4'h0, 4'(pdb_pkg::IDLE_MAX_STEPS))
        * pdb_pkg::IDLE_STEP_MS); // R1
    assign data_ms = 10'(clamp(pkt_q[pdb_pkg::PKT_DATA_LSB +: 4], 4'(pdb_pkg::DATA_MIN_STEPS),
        4'(pdb_pkg::DATA_MAX_STEPS)) * pdb_pkg::DATA_STEP_MS); // R2

    // error counters, index 0 primary and 1 secondary
    logic [13:0] be_q [2];
    logic [9:0] es_q [2];
    logic es_flag_q [2];
    logic err [2];
    logic sync [2];
    logic zero_all;
    logic restart;

    assign zero_all = be_q[0] == 14'h0 && be_q[1] == 14'h0 && es_q[0] == 10'h0 && es_q[1] == 10'h0;
    assign restart = cmd[pdb_pkg::CMD_RESTART];

    // elapsed time base, restarted by restart so seconds align to it
    logic [17:0] cyc_q;
    logic [9:0] ms_q;
    logic [23:0] elapsed_q;
    logic ms_tick;
    logic sec_tick;

    assign ms_tick = cyc_q == MS_LAST;
    assign sec_tick = ms_tick && ms_q == SEC_LAST;

    always_ff @(posedge clk_i) begin
        if (rst_i || restart) begin
            cyc_q <= 18'h0; // R16 R24
            ms_q <= 10'h0;
            elapsed_q <= 24'h0;
        end else begin
            cyc_q <= ms_tick ? 18'h0 : cyc_q + 18'h1;
            if (ms_tick) begin
                ms_q <= sec_tick ? 10'h0 : ms_q + 10'h1;
            end
            if (sec_tick) begin
                elapsed_q <= elapsed_q + 24'h1;
            end
        end
    end

    // setup menu, packet on flag and analysis view
    pdb_pkg::pdb_menu_t menu_q;
    logic pkt_on_q;
    logic [1:0] view_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            menu_q <= pdb_pkg::MENU_CLOSED;
            pkt_on_q <= 1'b0;
            view_q <= 2'h0;
        end else begin
            if (restart && zero_all) begin
                view_q <= view_q + 2'h1; // R18
            end
            if (cmd[pdb_pkg::CMD_STOP] || !run) begin
                pkt_on_q <= 1'b0; // R7
                menu_q <= pdb_pkg::MENU_CLOSED;
            end else begin
                case (menu_q)
                    pdb_pkg::MENU_CLOSED: begin
                        if (restart && zero_all && sync[0]) begin
                            menu_q <= pdb_pkg::MENU_OPEN; // R5
                        end
                    end
                    pdb_pkg::MENU_OPEN: begin
                        if (cmd[pdb_pkg::CMD_PKT_TOGGLE]) begin
                            pkt_on_q <= ~pkt_on_q & rate_ok; // R6 R4
                        end
                        if (cmd[pdb_pkg::CMD_PKT_EXIT]) begin
                            menu_q <= pdb_pkg::MENU_CLOSED; // R6
                        end
                    end
                    default: menu_q <= pdb_pkg::MENU_CLOSED;
                endcase
                if (!rate_ok) begin
                    pkt_on_q <= 1'b0; // R4
                end
            end
        end
    end

    // burst and idle phase timing
    pdb_pkg::pdb_phase_t phase_q;
    logic [9:0] ph_ms_q;
    logic idle_now;

    assign idle_now = pkt_on_q && phase_q == pdb_pkg::PH_IDLE;

    always_ff @(posedge clk_i) begin
        if (rst_i || !pkt_on_q) begin
            phase_q <= pdb_pkg::PH_DATA;
            ph_ms_q <= 10'h0;
        end else if (ms_tick) begin
            case (phase_q)
                pdb_pkg::PH_DATA: begin
                    if (ph_ms_q == data_ms - 10'h1) begin
                        ph_ms_q <= 10'h0;
                        // zero idle keeps bursts back to back
                        phase_q <= (idle_ms == 10'h0) ? pdb_pkg::PH_DATA : pdb_pkg::PH_IDLE; // R21
                    end else begin
                        ph_ms_q <= ph_ms_q + 10'h1;
                    end
                end
                pdb_pkg::PH_IDLE: begin
                    if (ph_ms_q >= idle_ms - 10'h1) begin
                        ph_ms_q <= 10'h0;
                        phase_q <= pdb_pkg::PH_DATA;
                    end else begin
                        ph_ms_q <= ph_ms_q + 10'h1;
                    end
                end
                default: phase_q <= pdb_pkg::PH_DATA;
            endcase
        end
    end

    // pending insert counts, drained one flipped bit per sent bit
    logic [7:0] ins_pri_q;
    logic [7:0] ins_sec_q;
    logic pri_tx_en;

    assign pri_tx_en = run & ~byte_mode & ~idle_now; // R3 R23

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ins_pri_q <= 8'h0;
            ins_sec_q <= 8'h0;
        end else begin
            if (cmd[pdb_pkg::CMD_INS_PRI] && ins_pri_q < 8'hf0) begin
                ins_pri_q <= ins_pri_q + {4'h0, pdb_pkg::PRI_INSERT_BITS}
                    - {7'h0, stb & pri_tx_en & (ins_pri_q != 8'h0)}; // R13
            end else if (stb && pri_tx_en && ins_pri_q != 8'h0) begin
                ins_pri_q <= ins_pri_q - 8'h1;
            end
            if (cmd[pdb_pkg::CMD_INS_SEC] && sec_on && ins_sec_q < 8'hf0) begin
                ins_sec_q <= ins_sec_q + {4'h0, pdb_pkg::SEC_INSERT_BITS}
                    - {7'h0, stb & (ins_sec_q != 8'h0)}; // R14
            end else if (stb && sec_on && ins_sec_q != 8'h0) begin
                ins_sec_q <= ins_sec_q - 8'h1;
            end
        end
    end

    // transmit byte framing, msb (S) first and C last
    logic [2:0] tx_idx_q;
    logic [7:0] tx_byte;
    logic lane_tx [2];
    logic tx_pri_q;
    logic tx_sec_q;
    logic chk_pri_q;

    assign tx_byte = (run && byte_mode) ? byte_q : pdb_pkg::IDLE_FILL_BYTE; // R9 R12 R21

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_idx_q <= 3'h7;
            tx_pri_q <= 1'b1;
            tx_sec_q <= 1'b1;
            chk_pri_q <= 1'b0;
        end else if (stb) begin
            // a strobe checks the bit sent at the one before
            chk_pri_q <= pri_tx_en; // R23
            tx_idx_q <= tx_idx_q - 3'h1;
            tx_pri_q <= pri_tx_en ? lane_tx[0] : tx_byte[tx_idx_q];
            tx_sec_q <= sec_on ? lane_tx[1] : 1'b1;
        end
    end

    pdb_lane u_pri (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_2047_i(ctrl_q[pdb_pkg::CTRL_P2047]),
        .step_i(stb),
        .tx_en_i(pri_tx_en),
        .flip_i(ins_pri_q != 8'h0),
        .rx_bit_i(pin_q[1]),
        .chk_en_i(chk_pri_q),
        .tx_bit_o(lane_tx[0]),
        .sync_o(sync[0]),
        .err_o(err[0])
    );

    pdb_lane u_sec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_2047_i(ctrl_q[pdb_pkg::CTRL_P2047]),
        .step_i(stb),
        .tx_en_i(sec_on),
        .flip_i(ins_sec_q != 8'h0),
        .rx_bit_i(pin_q[2]),
        .chk_en_i(sec_on),
        .tx_bit_o(lane_tx[1]),
        .sync_o(sync[1]),
        .err_o(err[1])
    );

    // bit error and errored second counts; an error in the tick cycle still counts
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || restart) begin
                be_q[i] <= 14'h0; // R16 R17
                es_q[i] <= 10'h0;
                es_flag_q[i] <= 1'b0;
            end else begin
                if (err[i] && be_q[i] != pdb_pkg::BE_MAX) begin
                    be_q[i] <= be_q[i] + 14'h1; // R8 R15
                end
                if (sec_tick) begin
                    es_flag_q[i] <= 1'b0;
                    if ((es_flag_q[i] || err[i]) && es_q[i] != pdb_pkg::ES_MAX) begin
                        es_q[i] <= es_q[i] + 10'h1; // R22 R24
                    end
                end else if (err[i]) begin
                    es_flag_q[i] <= 1'b1;
                end
            end
        end
    end

    // checked primary bits, the divisor for the error ratio
    logic [31:0] bits_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || restart) begin
            bits_q <= 32'h0;
        end else if (stb && chk_pri_q && sync[0]) begin
            bits_q <= bits_q + 32'h1; // R8
        end
    end

    // received byte: fixed framing so the shown byte never walks
    logic [7:0] rx_sh_q;
    logic [2:0] rx_idx_q;
    logic [7:0] rx_byte_q;
    pdb_pkg::pdb_class_t rx_cls_q;

    function automatic pdb_pkg::pdb_class_t classify(input logic [7:0] b, input logic [7:0] latch_select_byte,
        input logic lsc_en);
        if (lsc_en && b == latch_select_byte) begin
            return pdb_pkg::CLS_CODE;
        end
        if (b[0]) begin
            return (b == pdb_pkg::DATA_ALL_ONES) ? pdb_pkg::CLS_DATA : pdb_pkg::CLS_UDATA;
        end
        return (b == pdb_pkg::IDLE_FILL_BYTE) ? pdb_pkg::CLS_CODE : pdb_pkg::CLS_UCODE;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sh_q <= 8'h0;
            rx_idx_q <= 3'h0;
            rx_byte_q <= 8'h0;
            rx_cls_q <= pdb_pkg::CLS_UCODE;
        end else if (stb) begin
            rx_sh_q <= {rx_sh_q[6:0], pin_q[1]};
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) begin
                rx_byte_q <= {rx_sh_q[6:0], pin_q[1]}; // R10
                rx_cls_q <= classify({rx_sh_q[6:0], pin_q[1]}, byte_q, ctrl_q[pdb_pkg::CTRL_LSC]); // R11 R12
            end
        end
    end

    // read mux, loaded on the request cycle and held through ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0;
        end else if (req && !ack_q) begin
            case (wb_adr_i)
                pdb_pkg::ADR_CTRL: dat_q <= {25'h0, ctrl_q};
                pdb_pkg::ADR_PKT: dat_q <= {24'h0, pkt_q};
                pdb_pkg::ADR_BYTE: dat_q <= {23'h0, ~byte_q[0], byte_q};
                pdb_pkg::ADR_STAT: dat_q <= {22'h0, rx_cls_q, view_q, menu_q, pkt_on_q, idle_now,
                    rate_ok, sync[1], sync[0]}; // R19
                pdb_pkg::ADR_PRI: dat_q <= {6'h0, es_q[0], 2'h0, be_q[0]};
                pdb_pkg::ADR_SEC: dat_q <= {6'h0, es_q[1], 2'h0, be_q[1]};
                pdb_pkg::ADR_RXB: dat_q <= {22'h0, rx_cls_q, rx_byte_q};
                pdb_pkg::ADR_TIME: dat_q <= {8'h0, elapsed_q};
                pdb_pkg::ADR_BITS: dat_q <= bits_q;
                default: dat_q <= 32'h0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign tx_pri_o = tx_pri_q;
    assign tx_sec_o = tx_sec_q;
    assign sync_pri_o = sync[0];
    assign sync_sec_o = sync[1];
    assign pkt_on_o = pkt_on_q;
endmodule

// ===== pdb_pkg.sv
// constants shared by the packet-mode bit error rate test engine
// assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus
package pdb_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_PER_SEC = 1000;
    localparam int IDLE_STEP_MS = 10;
    localparam int IDLE_MAX_STEPS = 15;
    localparam int DATA_STEP_MS = 100;
    localparam int DATA_MIN_STEPS = 1;
    localparam int DATA_MAX_STEPS = 10;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_PKT = 8'h08;
    localparam logic [7:0] ADR_BYTE = 8'h0c;
    localparam logic [7:0] ADR_STAT = 8'h10;
    localparam logic [7:0] ADR_PRI = 8'h14;
    localparam logic [7:0] ADR_SEC = 8'h18;
    localparam logic [7:0] ADR_RXB = 8'h1c;
    localparam logic [7:0] ADR_TIME = 8'h20;
    localparam logic [7:0] ADR_BITS = 8'h24;

    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_P2047 = 1;
    localparam int CTRL_RATE = 2;
    localparam int CTRL_SEC_EN = 4;
    localparam int CTRL_ENC = 5;
    localparam int CTRL_LSC = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [1:0] RATE_56K = 2'h0;
    localparam logic [1:0] RATE_64K = 2'h1;

    // command register bits, write one to act
    localparam int CMD_RESTART = 0;
    localparam int CMD_PKT_TOGGLE = 1;
    localparam int CMD_PKT_EXIT = 2;
    localparam int CMD_INS_PRI = 3;
    localparam int CMD_INS_SEC = 4;
    localparam int CMD_STOP = 5;

    // packet register fields and reset
    localparam int PKT_IDLE_LSB = 0;
    localparam int PKT_DATA_LSB = 4;
    localparam logic [7:0] PKT_RESET = 8'h10;

    localparam logic [3:0] PRI_INSERT_BITS = 4'h6;
    localparam logic [3:0] SEC_INSERT_BITS = 4'h1;

    // checker lock and loss thresholds
    localparam logic [4:0] LOCK_RUN = 5'h10;
    localparam logic [4:0] LOSS_ERRS = 5'h10;

    // byte codes, values arbitrary
    localparam logic [7:0] IDLE_FILL_BYTE = 8'hfe;
    localparam logic [7:0] DATA_ALL_ONES = 8'hff;
    localparam logic [7:0] BYTE_RESET = 8'hff;

    localparam logic [13:0] BE_MAX = 14'h270f;
    localparam logic [9:0] ES_MAX = 10'h3e7;

    typedef enum logic [1:0] {
        CLS_DATA = 2'b00,
        CLS_CODE = 2'b01,
        CLS_UDATA = 2'b10,
        CLS_UCODE = 2'b11
    } pdb_class_t;

    typedef enum logic {
        MENU_CLOSED = 1'b0,
        MENU_OPEN = 1'b1
    } pdb_menu_t;

    typedef enum logic {
        PH_DATA = 1'b0,
        PH_IDLE = 1'b1
    } pdb_phase_t;
endpackage

// ===== pdb_lane.sv
// one pattern lane: 511/2047 generator and self-locking checker
// assumes step_i is a one-cycle bit strobe from the line clock
module pdb_lane (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sel_2047_i,
    input wire logic step_i,
    input wire logic tx_en_i,
    input wire logic flip_i,
    input wire logic rx_bit_i,
    input wire logic chk_en_i,
    output logic tx_bit_o,
    output logic sync_o,
    output logic err_o
);
    logic [10:0] gen_q;
    logic [10:0] chk_q;
    logic [4:0] run_q;
    logic [5:0] win_q;
    logic [4:0] bad_q;
    logic sync_q;
    logic err_q;
    logic tx_q;
    logic pred;
    logic miss;

    localparam logic [4:0] LOCK_RUN_M1 = pdb_pkg::LOCK_RUN - 5'h01;
    localparam logic [4:0] LOSS_M1 = pdb_pkg::LOSS_ERRS - 5'h01;

    // x^9+x^5+1 or x^11+x^9+1
    function automatic logic feedback(input logic [10:0] s, input logic long_seq);
        return long_seq ? (s[10] ^ s[8]) : (s[8] ^ s[4]);
    endfunction

    assign pred = feedback(chk_q, sel_2047_i);
    assign miss = rx_bit_i ^ pred;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_q <= 11'h7ff;
            tx_q <= 1'b0;
        end else if (step_i && tx_en_i) begin
            tx_q <= feedback(gen_q, sel_2047_i) ^ flip_i;
            gen_q <= {gen_q[9:0], feedback(gen_q, sel_2047_i)}; // R3 R20
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_q <= 11'h000;
            run_q <= 5'h00;
            win_q <= 6'h00;
            bad_q <= 5'h00;
            sync_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            err_q <= 1'b0;
            if (step_i && chk_en_i) begin
                if (!sync_q) begin
                    // seed from the line; an all-zero register never locks
                    chk_q <= {chk_q[9:0], rx_bit_i};
                    run_q <= miss ? 5'h00 : run_q + 5'h01;
                    if (!miss && run_q == LOCK_RUN_M1 && |chk_q) begin
                        sync_q <= 1'b1; // R19
                        win_q <= 6'h00;
                        bad_q <= 5'h00;
                    end
                end else begin
                    chk_q <= {chk_q[9:0], pred};
                    err_q <= miss; // R15
                    win_q <= win_q + 6'h01;
                    bad_q <= (&win_q) ? 5'h00 : bad_q + {4'h0, miss};
                    if (miss && bad_q == LOSS_M1) begin
                        sync_q <= 1'b0;
                        run_q <= 5'h00;
                    end
                end
            end
        end
    end

    assign tx_bit_o = tx_q;
    assign sync_o = sync_q;
    assign err_o = err_q;
endmodule

// ===== pdb_line_loop.sv
// loopback of the circuit under test with a free-running line bit clock
// assumes the engine's transmit pins are wired straight back to its receive pins
module pdb_line_loop (
    input wire logic clk_i,
    input wire logic tx_pri_i,
    input wire logic tx_sec_i,
    output logic line_clk_o = 1'b0,
    output logic rx_pri_o = 1'b1,
    output logic rx_sec_o = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // 24 clk bit period, both phases far above the filter
    always @(posedge clk_i) begin
        cnt <= (cnt == 11) ? 0 : cnt + 1;
        if (cnt == 11)
            line_clk_o <= !line_clk_o;
        rx_pri_o <= tx_pri_i;
        rx_sec_o <= tx_sec_i;
    end
endmodule

// ===== pdb_bert_chk.sv
// bus and packet-state checks on the engine's ports
// assumes one clock domain, clk_i, with rst_i synchronous active high
module pdb_bert_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_pri_o,
    input wire logic sync_pri_o,
    input wire logic sync_sec_o,
    input wire logic pkt_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic cmd_wr;
    assign cmd_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == pdb_pkg::ADR_CMD;
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_reset_idle: assert property (disable iff (1'b0) $past(rst_i) |-> !wb_ack_o && !pkt_on_o && tx_pri_o)
        else $error("reset idle");
    a_pkt_cause: assert property ($rose(pkt_on_o) |-> $past(cmd_wr && wb_dat_i[1])) else $error("pkt on");
    a_pkt_stop: assert property (cmd_wr && wb_dat_i[5] |=> !pkt_on_o) else $error("pkt stop");
    a_pkt_hold: assert property (pkt_on_o && !(wb_ack_o && wb_we_i) |=> pkt_on_o) else $error("pkt drop");
    a_cmd_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == pdb_pkg::ADR_CMD |-> wb_dat_o == 0)
        else $error("cmd read");
    a_hole_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h24 |-> wb_dat_o == 0) else $error("hole read");
    c_pkt_on: cover property ($rose(pkt_on_o));
    c_pri_sync: cover property ($rose(sync_pri_o));
    c_sec_sync: cover property ($rose(sync_sec_o));
endmodule
bind pdb_bert_top pdb_bert_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_pri_o(tx_pri_o), .sync_pri_o(sync_pri_o), .sync_sec_o(sync_sec_o), .pkt_on_o(pkt_on_o));

// ===== packet_mode_bert_engine_bench.sv
// self-checking bench: engine in loopback, registers driven over classic Wishbone
// assumes MS_CYCLES shortened to 20 so one second is 20000 clocks
module packet_mode_bert_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, lclk, rxp, rxs, txp, txs, syp, sys, pkt;
    logic [7:0] adr = 0, b;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, rdat, q;
    int failures = 0, tests_run = 0, cycles = 0, r;
    initial forever #2 clk_i = !clk_i;
    pdb_bert_top #(.MS_CYCLES(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_clk_i(lclk), .rx_pri_i(rxp), .rx_sec_i(rxs), .tx_pri_o(txp), .tx_sec_o(txs),
        .sync_pri_o(syp), .sync_sec_o(sys), .pkt_on_o(pkt));
    pdb_line_loop u_line (.clk_i(clk_i), .tx_pri_i(txp), .tx_sec_i(txs), .line_clk_o(lclk), .rx_pri_o(rxp),
        .rx_sec_o(rxs));
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk_reg(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: reg %h exp %h", $time, got, exp);
        end
    endtask
    task chk_pin(input logic exp);
        repeat (2) @(negedge clk_i);
        tests_run++;
        if (pkt !== exp) begin
            failures++;
            $display("Error %0t: pkt %b exp %b", $time, pkt, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50)
            failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin wb(1'b0, a, 0); n++; end while ((q & m) !== e && n < 8000);
        chk_reg(q & m, e);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        void'($urandom(73282));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 0);
        chk_reg(q, 0);
        wb(1'b0, 8'h08, 0);
        chk_reg(q, 32'h10);
        wb(1'b0, 8'h0c, 0);
        chk_reg(q & 32'hff, 32'hff);
        wb(1'b0, 8'h3c, 0);
        chk_reg(q, 0);
        $display("reset done");
        wb(1'b1, 8'h00, 32'h17);
        poll(8'h10, 32'h3, 32'h3);
        // 12 errors at most, under the sync loss count
        r = $urandom_range(2, 1);
        repeat (r) wb(1'b1, 8'h04, 32'h18);
        poll(8'h14, 32'h3fff, 32'(6 * r));
        poll(8'h18, 32'h3fff, 32'(r));
        poll(8'h20, 32'hffffff, 32'h1);
        wb(1'b0, 8'h14, 0);
        chk_reg(q, 32'h10000 | 32'(6 * r));
        $display("insert done");
        wb(1'b1, 8'h04, 32'h1);
        wb(1'b0, 8'h14, 0);
        chk_reg(q, 0);
        wb(1'b0, 8'h18, 0);
        chk_reg(q, 0);
        wb(1'b0, 8'h20, 0);
        chk_reg(q, 0);
        wb(1'b0, 8'h10, 0);
        chk_reg(q & 32'he0, 0);
        wb(1'b1, 8'h04, 32'h1);
        wb(1'b0, 8'h10, 0);
        chk_reg(q & 32'he0, 32'h60);
        $display("restart done");
        wb(1'b1, 8'h00, 32'h1b);
        wb(1'b1, 8'h04, 32'h2);
        chk_pin(1'b0);
        wb(1'b1, 8'h00, 32'h17);
        wb(1'b1, 8'h08, 32'h11);
        wb(1'b1, 8'h04, 32'h2);
        chk_pin(1'b1);
        poll(8'h10, 32'h18, 32'h18);
        poll(8'h10, 32'h18, 32'h10);
        wb(1'b1, 8'h04, 32'h8);
        poll(8'h14, 32'h3fff, 32'h6);
        wb(1'b1, 8'h04, 32'h4);
        wb(1'b0, 8'h10, 0);
        chk_reg(q & 32'h30, 32'h10);
        wb(1'b1, 8'h04, 32'h20);
        chk_pin(1'b0);
        $display("packet done");
        b = 8'($urandom_range(255, 0));
        wb(1'b1, 8'h0c, 32'(b));
        wb(1'b0, 8'h0c, 0);
        chk_reg(q & 32'h1ff, 32'(b) | (b[0] ? 32'h0 : 32'h100));
        wb(1'b1, 8'h0c, 32'hff);
        wb(1'b1, 8'h00, 32'h21);
        poll(8'h1c, 32'h3ff, 32'h0ff);
        $display("byte done");
        end_sim;
    end
endmodule
